/* standard_timer_pkg.sv */
/*
  Constants shared by the ten-bit compare/PWM/pulse timer: register byte
  offsets, control field positions, mode and pin-function encodings,
  clock-select codes and prescaler divide ratios.
  Assumes a 32-bit APB with each byte-wide register in its own word.
*/
`default_nettype none

package standard_timer_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;

  // Control register 0 fields
  localparam int CTRL0_PAUSE = 7;
  localparam int CTRL0_CKSEL_LSB = 4;
  localparam int CTRL0_ENABLE = 3;
  localparam int CTRL0_P_LSB = 0;

  // Control register 1 fields
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_PINF_LSB = 4;
  localparam int CTRL1_OUTCTL = 3;
  localparam int CTRL1_INVERT = 2;
  localparam int CTRL1_SWAP = 1;
  localparam int CTRL1_CLRSEL = 0;

  // Flag register fields, write one to clear
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CMPA_RESET = 10'h000;
  localparam logic [9:0] CNT_RESET = 10'h000;

  // Operating modes
  localparam logic [1:0] MODE_COMPARE = 2'b00;
  localparam logic [1:0] MODE_PWM = 2'b10;
  localparam logic [1:0] MODE_TIMER = 2'b11;

  // Pin function codes
  localparam logic [1:0] PINF_NONE = 2'b00;
  localparam logic [1:0] PINF_LOW = 2'b01;
  localparam logic [1:0] PINF_HIGH = 2'b10;
  localparam logic [1:0] PINF_TOGGLE = 2'b11;
  localparam logic [1:0] PINF_PWM = 2'b10;
  localparam logic [1:0] PINF_PULSE = 2'b11;

  // Clock select codes
  localparam logic [2:0] CK_SYS_DIV4 = 3'b000;
  localparam logic [2:0] CK_SYS = 3'b001;
  localparam logic [2:0] CK_H_DIV16 = 3'b010;
  localparam logic [2:0] CK_H_DIV64 = 3'b011;
  localparam logic [2:0] CK_SUB_A = 3'b100;
  localparam logic [2:0] CK_SUB_B = 3'b101;
  localparam logic [2:0] CK_PIN_RISE = 3'b110;
  localparam logic [2:0] CK_PIN_FALL = 3'b111;

  // Prescaler taps; the sub clock ratio is a plain stand-in value
  localparam int PRESC_W = 8;
  localparam int SUB_DIV = 256;

endpackage : standard_timer_pkg

`default_nettype wire

/* standard_timer.sv */
/*
  Ten-bit count-up timer with comparators A and P, working as compare
  output, timer/counter, edge-aligned PWM or single pulse, behind an APB
  slave with one wait state.
  Assumes all inputs synchronous to ref_clk_i; the high and system clocks
  are both taken as ref_clk_i, the sub clock as a fixed division of it.
*/
// Summary of operation
// - Counter readable as low byte plus two bits
// - Compare A in two writable bytes, reset zero
// - Mode field picks compare, timer or PWM; pulse is PWM with pin code 11
// - Clear-select low: P match clears, both flags
// - Clear-select high: A match clears, A flag only
// - Compare A zero: overflow at max, no flag
// - Compare mode pin changes on A match and enable rise
// - A match drives pin high, low or toggle
// - Enable rising loads pin initial level
// - Timer mode counts like compare, pin idle
// - PWM ignores clear-select; swap picks period
// - Swap low: period P times 128, duty A
// - Swap high: period A, duty P times 128
// - Duty at least period gives full duty
// - PWM raises A and P flags on matches
// - PWM active level, pin function, invert apply
// - PWM counting continues while pin forced
// - Pulse starts on enable rise or pin edge
// - Pulse ends on A match or enable clear
// - Pulse counter zeroed only on enable rise
// - Enable rise zeroes counter, fall holds count
// - P compares counter bits nine to seven
// - Pause freezes counter, release resumes
// - Clock select picks counter tick source
`timescale 1ns/100ps
`default_nettype none

module standard_timer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Timer pins
  input wire logic external_clock_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_oe_o
);

  // Software registers and timer state
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cmpa_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic enable_q;
  logic enable_d;
  logic enable_prev_q;
  logic match_a_flag_q;
  logic match_p_flag_q;
  logic cmp_state_q;
  logic cmp_state_d;
  logic pin_d;
  logic [standard_timer_pkg::PRESC_W-1:0] presc_q;
  logic [7:0] sub_cnt_q;
  logic sub_tick_q;
  logic ext_prev_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Field decode
  wire logic pause_bit = ctrl0_q[standard_timer_pkg::CTRL0_PAUSE];
  wire logic [2:0] clock_select_field = ctrl0_q[standard_timer_pkg::CTRL0_CKSEL_LSB +: 3];
  wire logic [2:0] compare_p_value = ctrl0_q[standard_timer_pkg::CTRL0_P_LSB +: 3];
  wire logic [1:0] mode_sel = ctrl1_q[standard_timer_pkg::CTRL1_MODE_LSB +: 2];
  wire logic [1:0] pin_function = ctrl1_q[standard_timer_pkg::CTRL1_PINF_LSB +: 2];
  wire logic output_control_bit = ctrl1_q[standard_timer_pkg::CTRL1_OUTCTL];
  wire logic output_invert_bit = ctrl1_q[standard_timer_pkg::CTRL1_INVERT];
  wire logic duty_period_swap_bit = ctrl1_q[standard_timer_pkg::CTRL1_SWAP];
  wire logic clear_select_bit = ctrl1_q[standard_timer_pkg::CTRL1_CLRSEL];

  // Mode decode
  wire logic mode_pwm_group = (mode_sel == standard_timer_pkg::MODE_PWM);
  wire logic mode_pulse = mode_pwm_group && (pin_function == standard_timer_pkg::PINF_PULSE);
  wire logic mode_pwm = mode_pwm_group && !mode_pulse;
  wire logic mode_cmp_out = (mode_sel == standard_timer_pkg::MODE_COMPARE);
  wire logic mode_timer = (mode_sel == standard_timer_pkg::MODE_TIMER);
  wire logic mode_cmp_like = mode_cmp_out || mode_timer;

  // APB decode; writes land on the single ready edge
  wire logic apb_access = psel_i && penable_i;
  wire logic apb_done = apb_access && pready_q;
  wire logic apb_wr = apb_done && pwrite_i;
  wire logic addr_ok = (paddr_i == standard_timer_pkg::OFS_CTRL0) ||
                       (paddr_i == standard_timer_pkg::OFS_CTRL1) ||
                       (paddr_i == standard_timer_pkg::OFS_CNT_LO) ||
                       (paddr_i == standard_timer_pkg::OFS_CNT_HI) ||
                       (paddr_i == standard_timer_pkg::OFS_CMPA_LO) ||
                       (paddr_i == standard_timer_pkg::OFS_CMPA_HI) ||
                       (paddr_i == standard_timer_pkg::OFS_FLAGS);
  wire logic wr_ctrl0 = apb_wr && (paddr_i == standard_timer_pkg::OFS_CTRL0);
  wire logic wr_ctrl1 = apb_wr && (paddr_i == standard_timer_pkg::OFS_CTRL1);
  wire logic wr_cmpa_lo = apb_wr && (paddr_i == standard_timer_pkg::OFS_CMPA_LO);
  wire logic wr_cmpa_hi = apb_wr && (paddr_i == standard_timer_pkg::OFS_CMPA_HI);
  wire logic wr_flags = apb_wr && (paddr_i == standard_timer_pkg::OFS_FLAGS);

  // Read mux; unused upper bits of every register read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      standard_timer_pkg::OFS_CTRL0: rd_mux = {24'h00_0000, ctrl0_q[7:4], enable_q, ctrl0_q[2:0]};
      standard_timer_pkg::OFS_CTRL1: rd_mux = {24'h00_0000, ctrl1_q};
      standard_timer_pkg::OFS_CNT_LO: rd_mux = {24'h00_0000, cnt_q[7:0]};
      standard_timer_pkg::OFS_CNT_HI: rd_mux = {30'h0000_0000, cnt_q[9:8]};
      standard_timer_pkg::OFS_CMPA_LO: rd_mux = {24'h00_0000, cmpa_q[7:0]};
      standard_timer_pkg::OFS_CMPA_HI: rd_mux = {30'h0000_0000, cmpa_q[9:8]};
      standard_timer_pkg::OFS_FLAGS: rd_mux = {30'h0000_0000, match_p_flag_q, match_a_flag_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_access && !pready_q;
      pslverr_q <= apb_access && !pready_q && !addr_ok;
      prdata_q <= (apb_access && !pready_q && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Free-running prescaler; every slower rate is a one-cycle enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= '0;
      sub_cnt_q <= 8'h00;
      sub_tick_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 1'b1;
      sub_cnt_q <= sub_cnt_q + 8'h01;
      sub_tick_q <= (sub_cnt_q == 8'(standard_timer_pkg::SUB_DIV - 1));
      ext_prev_q <= external_clock_pin_i;
    end
  end

  // Tick source selection
  wire logic ext_rise = external_clock_pin_i && !ext_prev_q;
  wire logic ext_fall = !external_clock_pin_i && ext_prev_q;
  logic src_tick;
  always_comb begin
    case (clock_select_field)
      standard_timer_pkg::CK_SYS_DIV4: src_tick = (presc_q[1:0] == 2'b11);
      standard_timer_pkg::CK_SYS: src_tick = 1'b1;
      standard_timer_pkg::CK_H_DIV16: src_tick = (presc_q[3:0] == 4'hF);
      standard_timer_pkg::CK_H_DIV64: src_tick = (presc_q[5:0] == 6'h3F);
      standard_timer_pkg::CK_SUB_A: src_tick = sub_tick_q;
      standard_timer_pkg::CK_SUB_B: src_tick = sub_tick_q;
      standard_timer_pkg::CK_PIN_RISE: src_tick = ext_rise;
      standard_timer_pkg::CK_PIN_FALL: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  // Pulse trigger edge follows the chosen pin polarity, rising otherwise
  wire logic pin_trigger = (clock_select_field == standard_timer_pkg::CK_PIN_FALL) ?
                           ext_fall : ext_rise;

  // Live tick: enabled, not paused, not on the restart cycle
  wire logic enable_rise = enable_q && !enable_prev_q;
  wire logic tick = src_tick && enable_q && !enable_rise && !pause_bit;

  // Comparators: A over all bits, P over bits nine to seven
  wire logic [9:0] p_last = {compare_p_value, 7'h00} - 10'h001; // 3FF when P is zero
  wire logic p_hit = (cnt_q == p_last);
  wire logic a_hit = (cmpa_q != 10'h000) && (cnt_q == cmpa_q - 10'h001);
  wire logic [10:0] p_span = {1'b0, p_last} + 11'h001; // P*128, or 1024 for zero

  // Clear choice per mode
  wire logic clear_hit = mode_pwm ? (duty_period_swap_bit ? a_hit : p_hit) :
                         clear_select_bit ? a_hit : p_hit;
  wire logic set_a = tick && a_hit;
  wire logic set_p = tick && p_hit && !mode_pulse &&
                     !(mode_cmp_like && clear_select_bit);

  // Duty and active phase for PWM and pulse
  // Pulse width always comes from A; swap only matters in PWM
  wire logic [10:0] duty_val = (duty_period_swap_bit && !mode_pulse) ? p_span : {1'b0, cmpa_q};
  wire logic pwm_active = ({1'b0, cnt_q} < duty_val); // full duty when duty >= period

  // Counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (enable_rise) begin
      cnt_d = standard_timer_pkg::CNT_RESET;
    end else if (tick) begin
      if (mode_pulse) begin
        cnt_d = a_hit ? cnt_q : cnt_q + 10'h001; // stop at A match
      end else if (clear_hit) begin
        cnt_d = standard_timer_pkg::CNT_RESET;
      end else begin
        cnt_d = cnt_q + 10'h001; // wraps at 3FF
      end
    end
  end

  // Enable bit: software, pin trigger, hardware clear on pulse end
  always_comb begin
    enable_d = enable_q;
    if (wr_ctrl0) begin
      enable_d = pwdata_i[standard_timer_pkg::CTRL0_ENABLE];
    end
    if (mode_pulse && pin_trigger) begin
      enable_d = 1'b1;
    end
    if (mode_pulse && tick && a_hit) begin
      enable_d = 1'b0;
    end
  end

  // Compare output state
  always_comb begin
    cmp_state_d = cmp_state_q;
    if (enable_rise) begin
      cmp_state_d = output_control_bit;
    end else if (mode_cmp_out && set_a) begin
      case (pin_function)
        standard_timer_pkg::PINF_LOW: cmp_state_d = 1'b0;
        standard_timer_pkg::PINF_HIGH: cmp_state_d = 1'b1;
        standard_timer_pkg::PINF_TOGGLE: cmp_state_d = !cmp_state_q;
        default: cmp_state_d = cmp_state_q; // no change on code zero
      endcase
    end
  end

  // Pin level per mode; timer mode just holds the pin
  logic raw_level;
  always_comb begin
    raw_level = 1'b0;
    if (mode_pulse) begin
      raw_level = enable_q && !enable_rise && pwm_active; // stale count on restart
    end else if (mode_pwm) begin
      case (pin_function)
        standard_timer_pkg::PINF_PWM: raw_level = pwm_active;
        standard_timer_pkg::PINF_LOW: raw_level = 1'b1; // forced active
        default: raw_level = 1'b0; // forced inactive
      endcase
    end
  end
  wire logic wave_level = output_control_bit ? raw_level : !raw_level;
  always_comb begin
    if (mode_cmp_out) begin
      pin_d = cmp_state_d ^ output_invert_bit;
    end else if (mode_pwm_group) begin
      pin_d = wave_level ^ output_invert_bit;
    end else begin
      pin_d = timer_output_pin_o;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl0_q <= standard_timer_pkg::CTRL_RESET;
      ctrl1_q <= standard_timer_pkg::CTRL_RESET;
      cmpa_q <= standard_timer_pkg::CMPA_RESET;
    end else begin
      if (wr_ctrl0) ctrl0_q <= pwdata_i[7:0];
      if (wr_ctrl1) ctrl1_q <= pwdata_i[7:0];
      if (wr_cmpa_lo) cmpa_q[7:0] <= pwdata_i[7:0];
      if (wr_cmpa_hi) cmpa_q[9:8] <= pwdata_i[1:0];
    end
  end

  // Flags: set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
    end else begin
      match_a_flag_q <= set_a ||
        (match_a_flag_q && !(wr_flags && pwdata_i[standard_timer_pkg::FLAG_A]));
      match_p_flag_q <= set_p ||
        (match_p_flag_q && !(wr_flags && pwdata_i[standard_timer_pkg::FLAG_P]));
    end
  end

  // Timer core state and pin flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= standard_timer_pkg::CNT_RESET;
      enable_q <= 1'b0;
      enable_prev_q <= 1'b0;
      cmp_state_q <= 1'b0;
      timer_output_pin_o <= 1'b0;
      timer_output_oe_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      enable_q <= enable_d;
      enable_prev_q <= enable_q;
      cmp_state_q <= cmp_state_d;
      timer_output_pin_o <= pin_d;
      timer_output_oe_o <= !mode_timer; // pin freed for other uses
    end
  end

  // Bus outputs straight from flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

endmodule // standard_timer

`default_nettype wire

/* standard_timer_properties.sv */
/* Concurrent checks on the timer's APB port and output pin.
   Assumes one clock domain and a master that holds each request. */
`timescale 1ns/100ps
`default_nettype none
module standard_timer_properties (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB side
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Timer pins
  input wire logic external_clock_pin_i,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] mode_q;
  // Access decode; the mode mirror lets pin checks follow the mode field
  wire logic acc = psel_i && penable_i;
  wire logic hit = acc && pready_o;
  wire logic mapped = paddr_i[1:0] == 2'h0 && paddr_i <= standard_timer_pkg::OFS_FLAGS;
  wire logic hi_reg = paddr_i == standard_timer_pkg::OFS_CNT_HI ||
                      paddr_i == standard_timer_pkg::OFS_CMPA_HI;
  wire logic tmr = mode_q == standard_timer_pkg::MODE_TIMER;
  // Mirror taken at the same edge as the write itself
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) mode_q <= 2'h0;
    else if (hit && pwrite_i && paddr_i == standard_timer_pkg::OFS_CTRL1) mode_q <= pwdata_i[7:6];
  end
  a_ready_wait: assert property ($rose(acc) |-> !pready_o ##1 pready_o)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_scope: assert property (pready_o |-> acc)
    else $error("ready outside an access phase");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero while idle");
  a_err_unmapped: assert property (hit && !mapped |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (hit && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  a_high_zero: assert property (hit && !pwrite_i && hi_reg |-> prdata_o[31:2] == 30'h0)
    else $error("unused high bits not zero");
  a_oe_timer: assert property (tmr && $past(tmr) |-> !timer_output_oe_o)
    else $error("pin driven in timer mode");
  a_pin_timer: assert property (tmr && $past(tmr) && $past(tmr, 2) |-> $stable(timer_output_pin_o))
    else $error("pin moved in timer mode");
  a_oe_live: assert property ($past(rst_n_i) && !tmr && !$past(tmr) |-> timer_output_oe_o)
    else $error("pin not driven outside timer mode");
  c_refused: cover property (hit && pslverr_o);
  c_pin_rise: cover property (timer_output_oe_o && $rose(timer_output_pin_o));
  c_timer: cover property (tmr && $past(tmr));
endmodule // standard_timer_properties

bind standard_timer standard_timer_properties props (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .external_clock_pin_i(external_clock_pin_i),
  .timer_output_pin_o(timer_output_pin_o),
  .timer_output_oe_o(timer_output_oe_o)
);
`default_nettype wire

/* timer_load.sv */
/* Load on the timer pins: edge source on the clock pin, pin meter.
   Assumes the pin is sampled on the timer's own clock. */
`timescale 1ns/100ps
`default_nettype none
module timer_load (
  // Clock
  input wire logic ref_clk_i,
  // Pins
  input wire logic pin_i,
  output logic trig_o
);
  int hi_w = 0;
  int per = 0;
  int edges = 0;
  int cnt_h = 0;
  int cnt_p = 0;
  logic last_q = 1'h0;
  initial trig_o = 1'h0;
  // Last high width, last rise-to-rise period, edge count
  always @(posedge ref_clk_i) begin
    cnt_h <= pin_i ? cnt_h + 1 : 0;
    cnt_p <= pin_i && !last_q ? 0 : cnt_p + 1;
    if (pin_i != last_q) edges <= edges + 1;
    if (!pin_i && last_q) hi_w <= cnt_h;
    if (pin_i && !last_q) per <= cnt_p + 1;
    last_q <= pin_i;
  end
  // Slow full edge pairs so a synchroniser never misses one
  task automatic kick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      trig_o <= 1'h1;
      repeat (3) @(posedge ref_clk_i);
      trig_o <= 1'h0;
      repeat (3) @(posedge ref_clk_i);
    end
  endtask
endmodule // timer_load
`default_nettype wire

/* ten_bit_compare_pwm_pulse_timer_test.sv */
/* Bench for the ten-bit timer: APB tasks and runs covering every mode.
   Assumes the load model drives the clock pin and meters the output. */
`timescale 1ns/100ps
`default_nettype none
module ten_bit_compare_pwm_pulse_timer_test;
  localparam logic [7:0] C0 = standard_timer_pkg::OFS_CTRL0;
  localparam logic [7:0] C1 = standard_timer_pkg::OFS_CTRL1;
  localparam logic [7:0] CL = standard_timer_pkg::OFS_CNT_LO;
  localparam logic [7:0] AL = standard_timer_pkg::OFS_CMPA_LO;
  localparam logic [7:0] AH = standard_timer_pkg::OFS_CMPA_HI;
  localparam logic [7:0] FL = standard_timer_pkg::OFS_FLAGS;
  // Bench-driven inputs, valid from time zero
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  wire logic [31:0] prdata_o;
  wire logic pready_o;
  wire logic pslverr_o;
  wire logic ext_pin;
  wire logic out_pin;
  wire logic out_oe;
  int n_mismatch = 0;
  int total_checks = 0;
  int e;
  logic [31:0] rd_v;
  logic [31:0] hold_v;
  logic err_v;
  standard_timer uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .external_clock_pin_i(ext_pin), .timer_output_pin_o(out_pin), .timer_output_oe_o(out_oe));
  timer_load ld (.ref_clk_i(ref_clk_i), .pin_i(out_pin), .trig_o(ext_pin));
  // Clock, 4 ns period
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int t;
    t = 0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= {24'h00_0000, d};
    psel_i <= 1'h1;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      t++;
    end while (pready_o !== 1'h1 && t < 20);
    if (t >= 20) begin
      n_mismatch++;
      end_sim();
    end
    rd_v = prdata_o;
    err_v = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'h1, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'h0, 8'h00);
    chk(nm, ex, rd_v);
  endtask
  task automatic set_a(input logic [9:0] v);
    wr(AL, v[7:0]);
    wr(AH, {6'h00, v[9:8]});
  endtask
  // Stop, clear flags, set mode, then start with an enable rise
  task automatic run(input logic [7:0] c1, input logic [7:0] c0);
    wr(C0, 8'h00);
    wr(FL, 8'h03);
    wr(C1, c1);
    wr(C0, c0);
  endtask
  task automatic hold(input logic [7:0] c0, input logic same);
    wr(C0, c0);
    apb(CL, 1'h0, 8'h00);
    hold_v = rd_v;
    repeat (30) @(posedge ref_clk_i);
    apb(CL, 1'h0, 8'h00);
    chk("count_hold", {31'h0, same}, {31'h0, rd_v === hold_v});
  endtask
  // Hang guard, well past the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    @(posedge ref_clk_i);
    for (int a = 0; a < 28; a += 4) rc("reset", a[7:0], 32'h0000_0000);
    rc("unmapped", 8'h1C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, err_v});
    wr(AL, 8'hA5);
    wr(AH, 8'hFF);
    rc("a_lo", AL, 32'h0000_00A5);
    rc("a_hi", AH, 32'h0000_0003);
    wr(CL, 8'h55);
    rc("cnt_ro", CL, 32'h0000_0000);
    set_a(10'h00A);
    run(8'h39, 8'h18);
    repeat (3) @(posedge ref_clk_i);
    chk("pin_init", 32'h0000_0001, {31'h0, out_pin});
    repeat (100) @(posedge ref_clk_i);
    chk("toggle_a", 32'h0000_0014, ld.per);
    rc("flags_a", FL, 32'h0000_0001);
    run(8'h38, 8'h19);
    repeat (600) @(posedge ref_clk_i);
    chk("toggle_p", 32'h0000_0100, ld.per);
    rc("flags_p", FL, 32'h0000_0003);
    wr(C0, 8'h00);
    wr(C1, 8'hC0); // leave compare mode before A goes to zero
    set_a(10'h000);
    run(8'hC0, 8'h18);
    e = ld.edges;
    repeat (1100) @(posedge ref_clk_i);
    rc("flags_ovf", FL, 32'h0000_0002);
    chk("timer_pin", e, ld.edges);
    chk("timer_oe", 32'h0000_0000, {31'h0, out_oe});
    hold(8'h98, 1'h1);
    hold(8'h18, 1'h0);
    hold(8'h10, 1'h1);
    set_a(10'h020);
    run(8'hA8, 8'h19);
    repeat (400) @(posedge ref_clk_i);
    chk("pwm_duty", 32'h0000_0020, ld.hi_w);
    chk("pwm_per", 32'h0000_0080, ld.per);
    rc("pwm_flags", FL, 32'h0000_0003);
    run(8'hAC, 8'h19);
    repeat (400) @(posedge ref_clk_i);
    chk("pwm_inv", 32'h0000_0060, ld.hi_w);
    set_a(10'h12C);
    run(8'hAB, 8'h19);
    repeat (1000) @(posedge ref_clk_i);
    chk("swap_per", 32'h0000_012C, ld.per);
    chk("swap_duty", 32'h0000_0080, ld.hi_w);
    set_a(10'h064);
    run(8'hAB, 8'h19);
    repeat (20) @(posedge ref_clk_i);
    e = ld.edges;
    repeat (400) @(posedge ref_clk_i);
    chk("full_duty", e, ld.edges);
    chk("full_pin", 32'h0000_0001, {31'h0, out_pin});
    run(8'h98, 8'h19);
    repeat (20) @(posedge ref_clk_i);
    e = ld.edges;
    hold(8'h19, 1'h0);
    chk("forced_pin", 32'h0000_0001, {31'h0, out_pin});
    chk("forced_edges", e, ld.edges);
    set_a(10'h032);
    run(8'hB8, 8'h18); // enable left high for the whole pulse
    repeat (200) @(posedge ref_clk_i);
    chk("pulse_w", 32'h0000_0032, ld.hi_w);
    rc("pulse_off", C0, 32'h0000_0010);
    rc("pulse_flag", FL, 32'h0000_0001);
    e = ld.edges;
    ld.kick(1);
    repeat (200) @(posedge ref_clk_i);
    chk("trig_pulse", e + 2, ld.edges);
    chk("trig_w", 32'h0000_0032, ld.hi_w);
    set_a(10'h000);
    run(8'hC0, 8'h68);
    ld.kick(5);
    rc("ext_rise", CL, 32'h0000_0005);
    run(8'hC0, 8'h78);
    ld.kick(5);
    rc("ext_fall", CL, 32'h0000_0005);
    end_sim();
  end
endmodule // ten_bit_compare_pwm_pulse_timer_test
`default_nettype wire
